// file: sar_ctrl_pkg.sv
// Shared constants, register map and state encoding of the conversion controller.
package sar_ctrl_pkg;

    // Result word and output coding.
    localparam int RESULT_W = 16;
    localparam logic [15:0] CODE_MSB_FLIP = 16'h8000;
    localparam logic [15:0] CODE_TOP = 16'hFFFF;
    localparam logic [15:0] CODE_BOTTOM = 16'h0000;

    // Register port geometry and map.
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam logic [3:0] REG_STATUS = 4'h0;
    localparam logic [3:0] REG_RESULT = 4'h4;
    localparam logic [3:0] REG_LAST = 4'h8;
    localparam logic [3:0] REG_CTRL = 4'hC;

    // Field positions.
    localparam int CTRL_CAPTURE_BIT = 0;
    localparam int CTRL_FLUSH_BIT = 1;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_PD_BIT = 1;
    localparam int STAT_CAPTURE_BIT = 2;
    localparam int STAT_COUNT_LSB = 8;
    localparam int RESULT_VALID_BIT = 31;
    localparam logic CTRL_CAPTURE_RESET = 1'b1;

    // Buffering.
    localparam int FIFO_DEPTH = 16;

    // Timing: times in ns, cycle counts derived from the 50 ns clock (least times round up).
    localparam int CLK_PERIOD_NS = 50;
    localparam int STEP_TIME_NS = 100;
    localparam int ACQ_TIME_NS = 400;
    localparam int STEP_CYCLES = (STEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ACQ_CYCLES = (ACQ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 16;

    // Controller states.
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_CONVERT,
        ST_FORM,
        ST_ACQUIRE
    } conv_state_t;

endpackage

// file: sar_register.sv
// Successive-approximation bit register: trial word and bit pointer.
`timescale 1ns/1ps
module sar_register #(
    parameter int WIDTH = 16
) (
    input wire logic i_sys_clk, // System clock.
    input wire logic i_reset, // Synchronous reset, active high.
    input wire logic i_load, // Start a new search with the MSB on trial.
    input wire logic i_step, // Resolve the bit under trial now.
    input wire logic i_keep, // Comparator says the trial bit stays set.
    output logic [WIDTH-1:0] o_trial, // Current trial word for the DAC.
    output logic o_done // One-cycle pulse after the last bit is resolved.
);

    localparam int IDX_W = $clog2(WIDTH);

    typedef struct packed {
        logic [WIDTH-1:0] code;
        logic [IDX_W-1:0] idx;
        logic active;
        logic done;
    } sar_regs_t;

    localparam sar_regs_t SAR_RESET = '{code: '0, idx: '0, active: 1'b0, done: 1'b0};

    sar_regs_t q;
    sar_regs_t d;

    // Each step either keeps or drops the bit under trial, then puts the next lower one on trial; the step on bit 0 ends the search instead.
    always_comb begin
        d = q;
        d.done = 1'b0;
        if (i_load) begin
            d.code = '0;
            d.code[WIDTH-1] = 1'b1;
            d.idx = IDX_W'(WIDTH - 1);
            d.active = 1'b1;
        end else if (i_step && q.active) begin
            d.code[q.idx] = i_keep;
            if (q.idx == '0) begin
                d.active = 1'b0;
                d.done = 1'b1;
            end else begin
                d.idx = q.idx - IDX_W'(1);
                d.code[q.idx - IDX_W'(1)] = 1'b1;
            end
        end
    end

    // State register.
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            q <= SAR_RESET;
        end else begin
            q <= d;
        end
    end

    assign o_trial = q.code;
    assign o_done = q.done;

endmodule // sar_register

// file: result_fifo.sv
// Synchronous result FIFO with valid/ready on both sides and a flush.
`timescale 1ns/1ps
module result_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input wire logic i_sys_clk, // System clock.
    input wire logic i_reset, // Synchronous reset, active high.
    input wire logic i_flush, // Empty the FIFO; wins over a push.
    input wire logic i_in_valid, // Writer offers a word.
    output logic o_in_ready, // FIFO has room.
    input wire logic [WIDTH-1:0] i_in_data, // Word offered.
    output logic o_out_valid, // Head word present.
    input wire logic i_out_ready, // Reader takes the head word.
    output logic [WIDTH-1:0] o_out_data, // Head word.
    output logic [$clog2(DEPTH+1)-1:0] o_count // Words held.
);

    localparam int PTR_W = $clog2(DEPTH);
    localparam int CNT_W = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PTR_W-1:0] wr_ptr;
        logic [PTR_W-1:0] rd_ptr;
        logic [CNT_W-1:0] count;
    } fifo_regs_t;

    fifo_regs_t q;
    fifo_regs_t d;
    logic push;
    logic pop;

    // Push and pop may happen in the same cycle; the count then stays put.
    always_comb begin
        d = q;
        push = i_in_valid && (q.count != CNT_W'(DEPTH));
        pop = i_out_ready && (q.count != '0);
        if (i_flush) begin
            d.wr_ptr = '0;
            d.rd_ptr = '0;
            d.count = '0;
        end else begin
            if (push) begin
                d.mem[q.wr_ptr] = i_in_data;
                d.wr_ptr = (q.wr_ptr == PTR_W'(DEPTH - 1)) ? '0 : q.wr_ptr + PTR_W'(1);
            end
            if (pop) begin
                d.rd_ptr = (q.rd_ptr == PTR_W'(DEPTH - 1)) ? '0 : q.rd_ptr + PTR_W'(1);
            end
            if (push && !pop) begin
                d.count = q.count + CNT_W'(1);
            end else if (pop && !push) begin
                d.count = q.count - CNT_W'(1);
            end
        end
    end

    // The storage itself needs no reset; only the pointers and the count do.
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            q.wr_ptr <= '0;
            q.rd_ptr <= '0;
            q.count <= '0;
            q.mem <= q.mem;
        end else begin
            q <= d;
        end
    end

    assign o_in_ready = (q.count != CNT_W'(DEPTH));
    assign o_out_valid = (q.count != '0);
    assign o_out_data = q.mem[q.rd_ptr];
    assign o_count = q.count;

endmodule // result_fifo

// file: sar_conversion_ctrl.sv
// Conversion controller: start detection, bit search, output coding and result port.
//
// Behaviour
// R01 - A falling convert_start_n ends acquisition and starts a conversion.
// R02 - The input is held at conversion start; later input changes are ignored.
// R03 - Sixteen bits are resolved by successive approximation, MSB first.
// R04 - After the search the code word is formed, then busy drops.
// R05 - Each result is ready at the end of its own conversion, no latency.
// R06 - The coding_select level picks straight binary or twos complement.
// R07 - Twos complement equals straight binary with the MSB inverted.
// R08 - Over-range input saturates to FFFF binary, 7FFF twos complement.
// R09 - Under-range input saturates to 0000 binary, 8000 twos complement.
// R10 - A running conversion is never restarted or aborted, not even by powerdown.
// R11 - convert_start_n low when busy drops gives timed acquisition, then auto restart.
// R12 - Busy rises when a conversion begins and stays high until the result is valid.
// R13 - The host trusts a result only after busy returned low.
//
// Chosen here: the register addresses and strobed register access.
`timescale 1ns/1ps
module sar_conversion_ctrl #(
    parameter int STEP_CYCLES = sar_ctrl_pkg::STEP_CYCLES,
    parameter int ACQ_CYCLES = sar_ctrl_pkg::ACQ_CYCLES,
    parameter int FIFO_DEPTH = sar_ctrl_pkg::FIFO_DEPTH
) (
    input wire logic i_sys_clk, // System clock, 20 MHz.
    input wire logic i_reset, // Synchronous reset, active high.
    input wire logic i_convert_start_n, // Convert start, active low.
    input wire logic i_coding_select, // High: straight binary, low: twos complement.
    input wire logic i_powerdown_input, // High: no new conversion is started.
    input wire logic i_comp_above, // Comparator: held input at or above DAC trial.
    input wire logic i_over_range, // Front end: held input above the reference span.
    input wire logic i_under_range, // Front end: held input below input_ground_sense.
    output logic o_busy, // Conversion in progress.
    output logic o_hold, // Sampling switches open, input held.
    output logic [15:0] o_dac_code, // Trial word driving the capacitor DAC.
    output logic [15:0] o_result, // Last completed result in the selected coding.
    input wire logic [3:0] i_addr, // Register byte address.
    input wire logic [31:0] i_wr_data, // Register write data.
    input wire logic i_wr_en, // Register write strobe.
    input wire logic i_rd_en, // Register read strobe.
    output logic [31:0] o_rd_data // Read data, valid the cycle after i_rd_en.
);

    localparam int CNT_W = sar_ctrl_pkg::CNT_W;
    localparam int FCNT_W = $clog2(FIFO_DEPTH + 1);

    typedef struct packed {
        sar_ctrl_pkg::conv_state_t state;
        logic start_prev;
        logic [CNT_W-1:0] step_cnt;
        logic [CNT_W-1:0] acq_cnt;
        logic over;
        logic under;
        logic busy;
        logic hold;
        logic [15:0] result;
        logic capture_en;
        logic flush;
        logic [31:0] rd_data;
    } ctrl_regs_t;

    localparam ctrl_regs_t CTRL_RESET = '{
        state: sar_ctrl_pkg::ST_IDLE,
        start_prev: 1'b1,
        step_cnt: '0,
        acq_cnt: '0,
        over: 1'b0,
        under: 1'b0,
        busy: 1'b0,
        hold: 1'b0,
        result: 16'h0000,
        capture_en: sar_ctrl_pkg::CTRL_CAPTURE_RESET,
        flush: 1'b0,
        rd_data: 32'h0000_0000
    };

    ctrl_regs_t q;
    ctrl_regs_t d;

    // Submodule wiring.
    logic sar_load;
    logic sar_step;
    logic [15:0] sar_trial;
    logic sar_done;
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [15:0] fifo_out_data;
    logic [FCNT_W-1:0] fifo_count;
    logic [15:0] formed_code;
    logic start_edge;
    logic result_taken;

    // Turn the raw search word into the output code, clamping out-of-range samples first.
    function automatic logic [15:0] format_code(
        input logic [15:0] search,
        input logic binary_sel,
        input logic over,
        input logic under
    );
        logic [15:0] straight;
        straight = search;
        if (over) begin
            straight = sar_ctrl_pkg::CODE_TOP; // [R08]
        end else if (under) begin
            straight = sar_ctrl_pkg::CODE_BOTTOM; // [R09]
        end
        if (binary_sel) begin
            format_code = straight; // [R06]
        end else begin
            format_code = straight ^ sar_ctrl_pkg::CODE_MSB_FLIP; // [R07]
        end
    endfunction

    // Bit search engine; its trial word drives the DAC pins directly.
    sar_register #(
        .WIDTH(sar_ctrl_pkg::RESULT_W)
    ) u_sar (
        .i_sys_clk(i_sys_clk),
        .i_reset(i_reset),
        .i_load(sar_load),
        .i_step(sar_step),
        .i_keep(i_comp_above),
        .o_trial(sar_trial),
        .o_done(sar_done)
    );

    // Results queue here so software may fall behind the conversion rate.
    result_fifo #(
        .WIDTH(sar_ctrl_pkg::RESULT_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .i_sys_clk(i_sys_clk),
        .i_reset(i_reset),
        .i_flush(q.flush),
        .i_in_valid(fifo_in_valid),
        .o_in_ready(fifo_in_ready),
        .i_in_data(formed_code),
        .o_out_valid(fifo_out_valid),
        .i_out_ready(fifo_out_ready),
        .o_out_data(fifo_out_data),
        .o_count(fifo_count)
    );

    // Inputs are synchronous, so a falling edge is a high-to-low pair of samples.
    assign start_edge = q.start_prev && !i_convert_start_n; // [R01]

    // The code uses the range flags latched at hold time, but coding_select is read live when the word is formed.
    assign formed_code = format_code(sar_trial, i_coding_select, q.over, q.under); // [R02]

    // A full FIFO stalls the end of a conversion instead of dropping the word.
    assign fifo_in_valid = (q.state == sar_ctrl_pkg::ST_FORM) && q.capture_en;
    assign result_taken = (q.state == sar_ctrl_pkg::ST_FORM) && (!q.capture_en || fifo_in_ready);

    // A read of the result register pops the head word when there is one.
    assign fifo_out_ready = i_rd_en && (i_addr == sar_ctrl_pkg::REG_RESULT) && fifo_out_valid;

    // Step pulses pace the search so the comparator settles before each decision.
    assign sar_step = (q.state == sar_ctrl_pkg::ST_CONVERT)
                      && (q.step_cnt == CNT_W'(STEP_CYCLES - 1)); // [R03]

    // Conversion sequencer.
    always_comb begin
        d = q;
        d.start_prev = i_convert_start_n;
        d.flush = 1'b0;
        sar_load = 1'b0;
        case (q.state)
            sar_ctrl_pkg::ST_IDLE: begin
                // Powerdown only blocks a new start; it never touches a running one.
                if (start_edge && !i_powerdown_input) begin
                    sar_load = 1'b1; // [R03]
                    d.state = sar_ctrl_pkg::ST_CONVERT;
                    d.hold = 1'b1; // [R01]
                    d.busy = 1'b1; // [R12]
                    d.over = i_over_range; // [R02]
                    d.under = i_under_range; // [R02]
                    d.step_cnt = '0;
                end
            end
            sar_ctrl_pkg::ST_CONVERT: begin
                // Further start edges and powerdown are ignored until the search ends.
                if (sar_done) begin
                    d.state = sar_ctrl_pkg::ST_FORM; // [R10]
                end else if (sar_step) begin
                    d.step_cnt = '0;
                end else begin
                    d.step_cnt = q.step_cnt + CNT_W'(1);
                end
            end
            sar_ctrl_pkg::ST_FORM: begin
                // The word lands in the result register on the same edge busy drops.
                if (result_taken) begin
                    d.result = formed_code; // [R04]
                    d.busy = 1'b0; // [R04] [R05] [R12]
                    d.hold = 1'b0;
                    d.acq_cnt = '0;
                    if (!i_convert_start_n) begin
                        d.state = sar_ctrl_pkg::ST_ACQUIRE; // [R11]
                    end else begin
                        d.state = sar_ctrl_pkg::ST_IDLE;
                    end
                end
            end
            sar_ctrl_pkg::ST_ACQUIRE: begin
                // Self-timed acquisition; releasing the start input ends the free run.
                if (i_convert_start_n || i_powerdown_input) begin
                    d.state = sar_ctrl_pkg::ST_IDLE;
                end else if (q.acq_cnt == CNT_W'(ACQ_CYCLES - 1)) begin
                    sar_load = 1'b1; // [R11]
                    d.state = sar_ctrl_pkg::ST_CONVERT;
                    d.hold = 1'b1;
                    d.busy = 1'b1; // [R12]
                    d.over = i_over_range;
                    d.under = i_under_range;
                    d.step_cnt = '0;
                end else begin
                    d.acq_cnt = q.acq_cnt + CNT_W'(1);
                end
            end
            default: begin
                d.state = sar_ctrl_pkg::ST_IDLE;
            end
        endcase

        // Register writes; unmapped addresses are ignored.
        if (i_wr_en && (i_addr == sar_ctrl_pkg::REG_CTRL)) begin
            d.capture_en = i_wr_data[sar_ctrl_pkg::CTRL_CAPTURE_BIT];
            d.flush = i_wr_data[sar_ctrl_pkg::CTRL_FLUSH_BIT];
        end

        // Register reads answer in the next cycle only; unmapped addresses read zero.
        d.rd_data = 32'h0000_0000;
        if (i_rd_en) begin
            if (i_addr == sar_ctrl_pkg::REG_STATUS) begin
                d.rd_data[sar_ctrl_pkg::STAT_BUSY_BIT] = q.busy;
                d.rd_data[sar_ctrl_pkg::STAT_PD_BIT] = i_powerdown_input;
                d.rd_data[sar_ctrl_pkg::STAT_CAPTURE_BIT] = q.capture_en;
                d.rd_data[sar_ctrl_pkg::STAT_COUNT_LSB +: FCNT_W] = fifo_count;
            end else if (i_addr == sar_ctrl_pkg::REG_RESULT) begin
                if (fifo_out_valid) begin
                    d.rd_data[15:0] = fifo_out_data;
                    d.rd_data[sar_ctrl_pkg::RESULT_VALID_BIT] = 1'b1;
                end
            end else if (i_addr == sar_ctrl_pkg::REG_LAST) begin
                d.rd_data[15:0] = q.result;
            end else if (i_addr == sar_ctrl_pkg::REG_CTRL) begin
                d.rd_data[sar_ctrl_pkg::CTRL_CAPTURE_BIT] = q.capture_en;
            end
        end
    end

    // State register.
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            q <= CTRL_RESET;
        end else begin
            q <= d;
        end
    end

    // Every output comes straight from a flip-flop.
    assign o_busy = q.busy;
    assign o_hold = q.hold;
    assign o_dac_code = sar_trial;
    assign o_result = q.result;
    assign o_rd_data = q.rd_data;

endmodule // sar_conversion_ctrl

// file: sar_conversion_ctrl_chk.sv
// Port-level assertion checker for the conversion controller.
`timescale 1ns/1ps
module sar_conversion_ctrl_chk #(
    parameter int STEP_CYCLES = 2
) (
    input wire logic i_sys_clk, // System clock.
    input wire logic i_reset, // Synchronous reset, active high.
    input wire logic i_convert_start_n, // Convert start, active low.
    input wire logic i_coding_select, // High: straight binary.
    input wire logic i_powerdown_input, // Blocks new starts.
    input wire logic i_over_range, // Input above the span.
    input wire logic i_under_range, // Input below ground sense.
    input wire logic [3:0] i_addr, // Register address.
    input wire logic i_rd_en, // Read strobe.
    input wire logic o_busy, // Conversion in progress.
    input wire logic o_hold, // Input held.
    input wire logic [15:0] o_dac_code, // Trial word.
    input wire logic [15:0] o_result, // Last result.
    input wire logic [31:0] o_rd_data // Read data.
);
    localparam int MIN_BUSY = 16 * STEP_CYCLES + 2;
    logic [15:0] busy_cnt_q;
    logic [1:0] range_q;

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_reset);

    // Busy length and the range flags that busy froze; a short busy means a skipped step.
    always_ff @(posedge i_sys_clk) begin
        busy_cnt_q <= (i_reset || !o_busy) ? 16'h0000 : busy_cnt_q + 16'h0001;
        if (i_reset) begin
            range_q <= 2'h0;
        end else if (!o_busy) begin
            range_q <= {i_over_range, i_under_range};
        end
    end

    start_busy_a: assert property (
        !o_busy && !i_powerdown_input && $fell(i_convert_start_n) |=> o_busy)
        else $error("start edge did not raise busy");
    busy_len_a: assert property (
        $fell(o_busy) && !$past(i_reset) |-> busy_cnt_q >= MIN_BUSY)
        else $error("busy ended before the bit search could finish");
    hold_busy_a: assert property (o_hold == o_busy)
        else $error("hold differs from busy");
    msb_first_a: assert property ($rose(o_busy) |-> o_dac_code == 16'h8000)
        else $error("search did not begin with the top bit");
    result_stable_a: assert property (
        !$past(i_reset) && !$fell(o_busy) |-> $stable(o_result))
        else $error("result moved while busy did not fall");
    sat_top_a: assert property (
        $fell(o_busy) && !$past(i_reset) && range_q[1]
        |-> o_result == (i_coding_select ? 16'hFFFF : 16'h7FFF))
        else $error("over range did not give the top code");
    sat_bottom_a: assert property (
        $fell(o_busy) && !$past(i_reset) && range_q == 2'h1
        |-> o_result == (i_coding_select ? 16'h0000 : 16'h8000))
        else $error("under range did not give the bottom code");
    auto_run_a: assert property (
        $fell(o_busy) && !$past(i_convert_start_n) && !i_powerdown_input
        ##1 (!i_convert_start_n && !i_powerdown_input)[*8] |-> ##[1:4] o_busy)
        else $error("held start did not relaunch a conversion");
    pd_block_a: assert property (!o_busy && i_powerdown_input |=> !o_busy)
        else $error("conversion started during power down");
    rd_idle_a: assert property (!i_rd_en |=> o_rd_data == 32'h0)
        else $error("read data without a read");
    unmapped_rd_a: assert property (i_rd_en && i_addr[1:0] != 2'h0 |=> o_rd_data == 32'h0)
        else $error("unmapped read gave data");
endmodule // sar_conversion_ctrl_chk

// file: analog_front_model.sv
// Behavioural analog front end: tracks a level, holds it while converting, compares.
`timescale 1ns/1ps
module analog_front_model (
    input wire logic i_clk, // System clock.
    input wire logic i_hold, // Sampling switches open.
    input wire logic [15:0] i_level, // Input level in steps.
    input wire logic [15:0] i_dac, // Trial word.
    output logic o_above // Held level at or above the trial word.
);
    logic [15:0] held_q = 16'h0000;

    // Track while sampling and freeze once held, so later input moves are invisible.
    always @(posedge i_clk) begin
        if (!i_hold) begin
            held_q <= i_level;
        end
    end

    // Ideal comparator; a real one adds noise near each transition.
    assign o_above = (held_q >= i_dac);
endmodule // analog_front_model

// file: sar_conversion_ctrl_tb.sv
// Self-checking testbench for the conversion controller.
`timescale 1ns/1ps
module sar_conversion_ctrl_tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cnv_n = 1'b1;
    logic coding = 1'b1;
    logic pd = 1'b0;
    logic over = 1'b0;
    logic under = 1'b0;
    logic rd_en = 1'b0;
    logic wr_en = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic [15:0] level = 16'h0000;
    logic above, busy, hold;
    logic [15:0] dac, result;
    logic [31:0] rdata, d;
    logic [15:0] q[$];
    logic [15:0] vals [6] = '{16'h0000, 16'h8000, 16'hFFFF, 16'h1234, 16'h0000, 16'hFFFF};
    int fail_count = 0;
    int comparisons = 0;

    // 20 MHz system clock.
    always #25 clk = ~clk;

    sar_conversion_ctrl u_dut (
        .i_sys_clk(clk), .i_reset(rst), .i_convert_start_n(cnv_n),
        .i_coding_select(coding), .i_powerdown_input(pd), .i_comp_above(above),
        .i_over_range(over), .i_under_range(under), .o_busy(busy), .o_hold(hold),
        .o_dac_code(dac), .o_result(result), .i_addr(addr), .i_wr_data(wdata),
        .i_wr_en(wr_en), .i_rd_en(rd_en), .o_rd_data(rdata));

    analog_front_model u_front (.i_clk(clk), .i_hold(hold), .i_level(level),
        .i_dac(dac), .o_above(above));

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected %s at %0t: got %h want %h", what, $time, got, exp);
        end
    endtask

    // Bounded wait for busy; running out ends the run.
    task automatic wait_busy(input logic v, input int lim);
        int n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (busy !== v && n < lim);
        if (busy !== v) begin
            fail_count++;
            $display("unexpected busy stuck at %0t", $time);
            report_and_stop();
        end
    endtask

    task automatic rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 v = rdata;
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask

    function automatic logic [15:0] code(input logic [15:0] v, input logic ov, un, bin);
        logic [15:0] r;
        r = ov ? 16'hFFFF : (un ? 16'h0000 : v);
        return bin ? r : r ^ 16'h8000;
    endfunction

    // Start one conversion, then move the input level so a late sample would show.
    task automatic conv_start(input logic [15:0] v, input logic ov, un);
        @(posedge clk);
        level <= v;
        over <= ov;
        under <= un;
        cnv_n <= 1'b0;
        q.push_back(code(v, ov, un, coding));
        wait_busy(1'b1, 4);
        @(posedge clk);
        cnv_n <= 1'b1;
        level <= ~v;
    endtask

    task automatic conv_end();
        wait_busy(1'b0, 60);
        chk(32'(result), 32'(q[$]), "result");
    endtask

    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        rd(sar_ctrl_pkg::REG_CTRL, d);
        chk(d, 32'h1, "ctrl reset");
        wr(4'h2, 32'hFFFF_FFFF);
        rd(4'h2, d);
        chk(d, 32'h0, "unmapped");
        // Both codings against end codes, midscale, a plain value and both range faults.
        for (int m = 0; m < 2; m++) begin
            @(posedge clk);
            coding <= m[0];
            for (int k = 0; k < 6; k++) begin
                conv_start(vals[k], k == 4, k == 5);
                conv_end();
            end
        end
        $display("test codes done");
        // Fill the buffer, stall the next conversion, then drain in order.
        for (int k = 0; k < 4; k++) begin
            conv_start(16'h0F0F + 16'(k), 1'b0, 1'b0);
            conv_end();
        end
        rd(sar_ctrl_pkg::REG_STATUS, d);
        chk(d & 32'h1F00, 32'h1000, "count full");
        conv_start(16'h4321, 1'b0, 1'b0);
        repeat (60) @(posedge clk);
        #1 chk(32'(busy), 32'h1, "stall");
        for (int k = 0; k < 17; k++) begin
            rd(sar_ctrl_pkg::REG_RESULT, d);
            chk(d, {1'b1, 15'h0, q.pop_front()}, "fifo order");
        end
        rd(sar_ctrl_pkg::REG_RESULT, d);
        chk(d, 32'h0, "empty");
        rd(sar_ctrl_pkg::REG_LAST, d);
        chk(d, 32'h4321, "last");
        conv_start(16'h7777, 1'b0, 1'b0);
        conv_end();
        wr(sar_ctrl_pkg::REG_CTRL, 32'h3);
        rd(sar_ctrl_pkg::REG_STATUS, d);
        chk(d & 32'h1F07, 32'h4, "flush");
        wr(sar_ctrl_pkg::REG_CTRL, 32'h0);
        $display("test buffer done");
        // A new start edge and power-down in mid conversion change nothing.
        conv_start(16'hA5A5, 1'b0, 1'b0);
        @(posedge clk);
        cnv_n <= 1'b0;
        pd <= 1'b1;
        rd(sar_ctrl_pkg::REG_STATUS, d);
        chk(d & 32'h3, 32'h3, "status");
        conv_end();
        @(posedge clk);
        cnv_n <= 1'b1;
        pd <= 1'b0;
        // Start held low keeps the converter running by itself.
        @(posedge clk);
        level <= 16'h3C3C;
        cnv_n <= 1'b0;
        wait_busy(1'b1, 4);
        wait_busy(1'b0, 60);
        wait_busy(1'b1, 14);
        wait_busy(1'b0, 60);
        chk(32'(result), 32'h3C3C, "auto result");
        @(posedge clk);
        cnv_n <= 1'b1;
        $display("test control done");
        // Reset in mid conversion.
        conv_start(16'h0001, 1'b0, 1'b0);
        repeat (4) @(posedge clk);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        #1 chk(32'({busy, result}), 32'h0, "reset");
        $display("test reset done");
        report_and_stop();
    end
endmodule // sar_conversion_ctrl_tb

bind sar_conversion_ctrl sar_conversion_ctrl_chk #(.STEP_CYCLES(STEP_CYCLES)) u_chk (
    .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_convert_start_n(i_convert_start_n),
    .i_coding_select(i_coding_select), .i_powerdown_input(i_powerdown_input),
    .i_over_range(i_over_range), .i_under_range(i_under_range), .i_addr(i_addr),
    .i_rd_en(i_rd_en), .o_busy(o_busy), .o_hold(o_hold), .o_dac_code(o_dac_code),
    .o_result(o_result), .o_rd_data(o_rd_data));
